// ===== hdl/orm_map.svh
`ifndef ORM_MAP_SVH
`define ORM_MAP_SVH

// ---------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------
`define ORM_ADDR_W        12
`define ORM_QAW           5
`define ORM_QDEPTH        32
`define ORM_NQ            4
`define ORM_MBOX_W        16
`define ORM_FULL_BE       4'hF

// ---------------------------------------------------------------------
// Register offsets from the first base address
// ---------------------------------------------------------------------
`define ORM_OFS_HQ_STAT   12'h030
`define ORM_OFS_HQ_MASK   12'h034
`define ORM_OFS_LQ_STAT   12'h038
`define ORM_OFS_LQ_MASK   12'h03C
`define ORM_OFS_PORT_IFP  12'h040
`define ORM_OFS_PORT_OPF  12'h044
`define ORM_OFS_PORT_IPF  12'h048
`define ORM_OFS_PORT_OFP  12'h04C
`define ORM_OFS_DAW       12'h460
`define ORM_OFS_SM_CMD    12'h4A0
`define ORM_OFS_SM_RDATA  12'h4A4
`define ORM_OFS_SM_STAT   12'h4A8
`define ORM_OFS_X_LBASE   12'h4B0
`define ORM_OFS_X_HBASE   12'h4B4
`define ORM_OFS_X_LEN     12'h4B8
`define ORM_OFS_X_CTRL    12'h4BC
`define ORM_OFS_ARB       12'h4C0
`define ORM_OFS_HOST_CONTROL      12'h4E0
`define ORM_OFS_HIRQ      12'h4E4
`define ORM_OFS_H2L_MBOX  12'h4E8
`define ORM_OFS_LIRQ      12'h4F4
`define ORM_OFS_L2H_MBOX  12'h4F8
`define ORM_OFS_LBCFG     12'h4FC

// ---------------------------------------------------------------------
// Queue identities and fields
// ---------------------------------------------------------------------
`define ORM_Q_IN_FREE     2'h0
`define ORM_Q_IN_POST     2'h1
`define ORM_Q_OUT_POST    2'h2
`define ORM_Q_OUT_FREE    2'h3
`define ORM_Q_EMPTY_DATA  32'hFFFF_FFFF
`define ORM_QSTAT_BIT     3
`define ORM_QMASK_BIT     3
`define ORM_QMASK_RST     32'hFFFF_FFFF

// ---------------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------------
`define ORM_HOST_CONTROL_RST      2'h1
`define ORM_HOST_CONTROL_SBIT     1
`define ORM_LBCFG_RST     32'h0001_0B50
`define ORM_ARB_MASK      32'h0303_0303
`define ORM_XCTL_MASK     32'h0000_FFFF
`define ORM_XADDR_MASK    32'h0000_3FFF
`define ORM_ALL_MASK      32'hFFFF_FFFF

`endif

// ===== hdl/orm_pkg.sv
`include "orm_map.svh"

package orm_pkg;

	// -----------------------------------------------------------------
	// Register access port
	// -----------------------------------------------------------------
	typedef struct packed {
		logic                     valid;
		logic                     write;
		logic [`ORM_ADDR_W-1:0]   addr;
		logic [3:0]               be;
		logic [31:0]              wdata;
	} orm_req_t;

	typedef struct packed {
		logic                     valid;
		logic [31:0]              rdata;
	} orm_resp_t;

	// -----------------------------------------------------------------
	// Engine side
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [31:0]              direct_access_window;
		logic [31:0]              serial_mem_command;
		logic                     serial_mem_strobe;
		logic [31:0]              xfer_local_base;
		logic [31:0]              xfer_host_base;
		logic [31:0]              xfer_length;
		logic [31:0]              xfer_control;
		logic [31:0]              arbitration_flags;
		logic [1:0]               host_control;
		logic [`ORM_MBOX_W-1:0]   host_to_local_mailbox;
		logic [`ORM_MBOX_W-1:0]   local_to_host_mailbox;
		logic [31:0]              local_bus_config;
	} orm_ctrl_t;

	typedef struct packed {
		logic [31:0]              serial_mem_read_data;
		logic [1:0]               serial_mem_status;
		logic [15:0]              host_irq_events;
		logic [15:0]              local_irq_events;
	} orm_stat_t;

	typedef struct packed {
		logic                     host_queue_mask;
		logic                     local_queue_mask;
		logic [31:0]              direct_access_window;
		logic [31:0]              serial_mem_command;
		logic [31:0]              xfer_local_base;
		logic [31:0]              xfer_host_base;
		logic [31:0]              xfer_length;
		logic [31:0]              xfer_control;
		logic [31:0]              arbitration_flags;
		logic [1:0]               host_control;
		logic [15:0]              host_irq_enable;
		logic [15:0]              host_irq_status;
		logic [`ORM_MBOX_W-1:0]   host_to_local_mailbox;
		logic [15:0]              local_irq_enable;
		logic [15:0]              local_irq_status;
		logic [`ORM_MBOX_W-1:0]   local_to_host_mailbox;
		logic [31:0]              local_bus_config;
	} orm_regs_t;

	typedef struct packed {
		orm_regs_t                        regs;
		logic                             serial_mem_strobe;
		logic [`ORM_NQ-1:0][`ORM_QAW:0]   wr_ptr;
		logic [`ORM_NQ-1:0][`ORM_QAW:0]   rd_ptr;
		logic                             s1_valid;
		logic                             s1_from_q;
		logic                             s1_empty;
		logic [1:0]                       s1_q;
		logic [31:0]                      s1_data;
		logic                             resp_valid;
		logic [31:0]                      resp_rdata;
	} orm_state_t;

endpackage : orm_pkg

// ===== hdl/orm_queue_mem.sv
`include "orm_map.svh"

module orm_queue_mem
(
	input  wire logic                  mclk,
	input  wire logic                  wr_en,
	input  wire logic [`ORM_QAW-1:0]   wr_addr,
	input  wire logic [31:0]           wr_data,
	input  wire logic [`ORM_QAW-1:0]   rd_addr,
	output logic      [31:0]           rd_data
);

	logic [31:0] mem [`ORM_QDEPTH];

	always_ff @(posedge mclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : orm_queue_mem

// ===== hdl/orm_operations_regs.sv
// Summary of operation
// - Each register sits at a fixed offset from the base, one word each.
// - The offset is the lowest byte; the next three bytes follow it.
// - Unused bits read as zero unless a register names another value.
// - At 0x0040 a read pops inbound free, a write pushes inbound post.
// - At 0x0044 a read pops outbound post, a write pushes outbound free.
// - At 0x0048 a read pops inbound post, a write pushes inbound free.
// - At 0x004C a read pops outbound free, a write pushes outbound post.
// - An empty queue reads as all ones; a write to a full queue is lost.
// - All queues start empty and the bus reset flushes them.
// - Bit 3 flags outbound post (0x0030) or inbound post (0x0038) not empty; mask and spares reset to 1.
`include "orm_map.svh"

module orm_operations_regs
(
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	input  wire orm_pkg::orm_req_t    req,
	output orm_pkg::orm_resp_t        resp,
	output orm_pkg::orm_ctrl_t        ctrl,
	input  wire orm_pkg::orm_stat_t   stat,
	output logic                      host_queue_irq,
	output logic                      local_queue_irq,
	output logic                      host_irq,
	output logic                      local_irq
);

	import orm_pkg::*;

	// -----------------------------------------------------------------
	// Helper functions
	// -----------------------------------------------------------------
	function automatic logic ofs_hit(input logic [`ORM_ADDR_W-1:0] a,
		input logic [`ORM_ADDR_W-1:0] ofs);
		ofs_hit = (a[`ORM_ADDR_W-1:2] == ofs[`ORM_ADDR_W-1:2]);
	endfunction : ofs_hit

	// Byte lane n carries offset+n; only writable bits change.
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be,
		input logic [31:0] wmask);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		be_merge = (old & ~(lane & wmask)) | (wdata & lane & wmask);
	endfunction : be_merge

	function automatic logic q_empty(input logic [`ORM_QAW:0] wp,
		input logic [`ORM_QAW:0] rp);
		q_empty = (wp == rp);
	endfunction : q_empty

	function automatic logic q_full(input logic [`ORM_QAW:0] wp,
		input logic [`ORM_QAW:0] rp);
		q_full = (wp[`ORM_QAW] != rp[`ORM_QAW]) &&
			(wp[`ORM_QAW-1:0] == rp[`ORM_QAW-1:0]);
	endfunction : q_full

	// Queue port decode: bit 4 says a port was hit, then the queue
	// popped on read and the queue pushed on write.
	function automatic logic [4:0] port_decode(
		input logic [`ORM_ADDR_W-1:0] a);
		port_decode = 5'h00;
		if (ofs_hit(a, `ORM_OFS_PORT_IFP))
		begin
			port_decode = {1'b1, `ORM_Q_IN_FREE, `ORM_Q_IN_POST};
		end
		else if (ofs_hit(a, `ORM_OFS_PORT_OPF))
		begin
			port_decode = {1'b1, `ORM_Q_OUT_POST, `ORM_Q_OUT_FREE};
		end
		else if (ofs_hit(a, `ORM_OFS_PORT_IPF))
		begin
			port_decode = {1'b1, `ORM_Q_IN_POST, `ORM_Q_IN_FREE};
		end
		else if (ofs_hit(a, `ORM_OFS_PORT_OFP))
		begin
			port_decode = {1'b1, `ORM_Q_OUT_FREE, `ORM_Q_OUT_POST};
		end
	endfunction : port_decode

	function automatic orm_regs_t reg_defaults();
		orm_regs_t r;
		r = '0;
		r.host_queue_mask  = 1'b1;
		r.local_queue_mask = 1'b1;
		r.host_control     = `ORM_HOST_CONTROL_RST;
		r.local_bus_config = `ORM_LBCFG_RST;
		reg_defaults = r;
	endfunction : reg_defaults

	// -----------------------------------------------------------------
	// State and queue storage
	// -----------------------------------------------------------------
	orm_state_t                  st;
	orm_state_t                  next_st;
	logic [`ORM_NQ-1:0]          push;
	logic [`ORM_NQ-1:0][31:0]    mem_rdata;
	logic [`ORM_NQ-1:0]          not_empty;
	logic [4:0]                  pdec;
	logic                        port_hit;
	logic [1:0]                  rd_q;
	logic [1:0]                  wr_q;
	logic [31:0]                 rd_word;
	logic [31:0]                 qmask_word;

	genvar gi;
	generate
		for (gi = 0; gi < `ORM_NQ; gi++)
		begin : g_queue
			orm_queue_mem u_mem
			(
				.mclk    (mclk),
				.wr_en   (push[gi]),
				.wr_addr (st.wr_ptr[gi][`ORM_QAW-1:0]),
				.wr_data (req.wdata),
				.rd_addr (st.rd_ptr[gi][`ORM_QAW-1:0]),
				.rd_data (mem_rdata[gi])
			);
			assign not_empty[gi] = ~q_empty(st.wr_ptr[gi], st.rd_ptr[gi]);
		end
	endgenerate

	assign pdec     = port_decode(req.addr);
	assign port_hit = pdec[4];
	assign rd_q     = pdec[3:2];
	assign wr_q     = pdec[1:0];

	// -----------------------------------------------------------------
	// Read data of the plain registers
	// -----------------------------------------------------------------
	always_comb
	begin
		qmask_word = `ORM_QMASK_RST;
		rd_word    = '0;
		if (ofs_hit(req.addr, `ORM_OFS_HQ_STAT))
			rd_word[`ORM_QSTAT_BIT] = not_empty[`ORM_Q_OUT_POST];
		else if (ofs_hit(req.addr, `ORM_OFS_HQ_MASK))
		begin
			qmask_word[`ORM_QMASK_BIT] = st.regs.host_queue_mask;
			rd_word = qmask_word;
		end
		else if (ofs_hit(req.addr, `ORM_OFS_LQ_STAT))
			rd_word[`ORM_QSTAT_BIT] = not_empty[`ORM_Q_IN_POST];
		else if (ofs_hit(req.addr, `ORM_OFS_LQ_MASK))
		begin
			qmask_word[`ORM_QMASK_BIT] = st.regs.local_queue_mask;
			rd_word = qmask_word;
		end
		else if (ofs_hit(req.addr, `ORM_OFS_DAW))
			rd_word = st.regs.direct_access_window;
		else if (ofs_hit(req.addr, `ORM_OFS_SM_RDATA))
			rd_word = stat.serial_mem_read_data;
		else if (ofs_hit(req.addr, `ORM_OFS_SM_STAT))
			rd_word[1:0] = stat.serial_mem_status;
		else if (ofs_hit(req.addr, `ORM_OFS_X_LBASE))
			rd_word = st.regs.xfer_local_base;
		else if (ofs_hit(req.addr, `ORM_OFS_X_HBASE))
			rd_word = st.regs.xfer_host_base;
		else if (ofs_hit(req.addr, `ORM_OFS_X_LEN))
			rd_word = st.regs.xfer_length;
		else if (ofs_hit(req.addr, `ORM_OFS_X_CTRL))
			rd_word = st.regs.xfer_control;
		else if (ofs_hit(req.addr, `ORM_OFS_ARB))
			rd_word = st.regs.arbitration_flags;
		else if (ofs_hit(req.addr, `ORM_OFS_HOST_CONTROL))
			rd_word[1:0] = st.regs.host_control;
		else if (ofs_hit(req.addr, `ORM_OFS_HIRQ))
			rd_word = {st.regs.host_irq_enable, st.regs.host_irq_status};
		else if (ofs_hit(req.addr, `ORM_OFS_H2L_MBOX))
			rd_word[`ORM_MBOX_W-1:0] = st.regs.host_to_local_mailbox;
		else if (ofs_hit(req.addr, `ORM_OFS_LIRQ))
			rd_word = {st.regs.local_irq_enable, st.regs.local_irq_status};
		else if (ofs_hit(req.addr, `ORM_OFS_L2H_MBOX))
			rd_word[`ORM_MBOX_W-1:0] = st.regs.local_to_host_mailbox;
		else if (ofs_hit(req.addr, `ORM_OFS_LBCFG))
			rd_word = st.regs.local_bus_config;
	end

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb
	begin
		next_st                   = st;
		push                      = '0;
		next_st.serial_mem_strobe = 1'b0;

		// Interrupt status: the write-one clear is applied first, so an
		// event in the same cycle still sets its bit.
		if (req.valid && req.write && ofs_hit(req.addr, `ORM_OFS_HIRQ))
		begin
			next_st.regs.host_irq_status = st.regs.host_irq_status &
				~(req.wdata[15:0] & {{8{req.be[1]}}, {8{req.be[0]}}});
		end
		if (req.valid && req.write && ofs_hit(req.addr, `ORM_OFS_LIRQ))
		begin
			next_st.regs.local_irq_status = st.regs.local_irq_status &
				~(req.wdata[15:0] & {{8{req.be[1]}}, {8{req.be[0]}}});
		end
		next_st.regs.host_irq_status  = next_st.regs.host_irq_status |
			stat.host_irq_events;
		next_st.regs.local_irq_status = next_st.regs.local_irq_status |
			stat.local_irq_events;

		// Read pipeline: decode, then one registered answer.
		next_st.s1_valid  = req.valid && !req.write;
		next_st.s1_from_q = port_hit;
		next_st.s1_q      = rd_q;
		next_st.s1_empty  = !not_empty[rd_q];
		next_st.s1_data   = rd_word;
		next_st.resp_valid = st.s1_valid;
		if (st.s1_from_q)
		begin
			next_st.resp_rdata = st.s1_empty ? `ORM_Q_EMPTY_DATA
				: mem_rdata[st.s1_q];
		end
		else
		begin
			next_st.resp_rdata = st.s1_data;
		end

		if (req.valid && port_hit)
		begin
			if (!req.write && not_empty[rd_q])
			begin
				next_st.rd_ptr[rd_q] = st.rd_ptr[rd_q] + 1'b1;
			end
			else if (req.write && req.be == `ORM_FULL_BE &&
				!q_full(st.wr_ptr[wr_q], st.rd_ptr[wr_q]))
			begin
				push[wr_q]           = 1'b1;
				next_st.wr_ptr[wr_q] = st.wr_ptr[wr_q] + 1'b1;
			end
		end
		else if (req.valid && req.write)
		begin
			if (ofs_hit(req.addr, `ORM_OFS_HQ_MASK) && req.be[0])
			begin
				next_st.regs.host_queue_mask =
					req.wdata[`ORM_QMASK_BIT];
			end
			if (ofs_hit(req.addr, `ORM_OFS_LQ_MASK) && req.be[0])
			begin
				next_st.regs.local_queue_mask =
					req.wdata[`ORM_QMASK_BIT];
			end
			if (ofs_hit(req.addr, `ORM_OFS_DAW))
				next_st.regs.direct_access_window = be_merge(
					st.regs.direct_access_window, req.wdata, req.be,
					`ORM_ALL_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_SM_CMD))
			begin
				next_st.regs.serial_mem_command = be_merge(
					st.regs.serial_mem_command, req.wdata, req.be,
					`ORM_ALL_MASK);
				next_st.serial_mem_strobe = 1'b1;
			end
			if (ofs_hit(req.addr, `ORM_OFS_X_LBASE))
				next_st.regs.xfer_local_base = be_merge(
					st.regs.xfer_local_base, req.wdata, req.be,
					`ORM_XADDR_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_X_HBASE))
				next_st.regs.xfer_host_base = be_merge(
					st.regs.xfer_host_base, req.wdata, req.be,
					`ORM_ALL_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_X_LEN))
				next_st.regs.xfer_length = be_merge(st.regs.xfer_length,
					req.wdata, req.be, `ORM_XADDR_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_X_CTRL))
				next_st.regs.xfer_control = be_merge(st.regs.xfer_control,
					req.wdata, req.be, `ORM_XCTL_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_ARB))
				next_st.regs.arbitration_flags = be_merge(
					st.regs.arbitration_flags, req.wdata, req.be,
					`ORM_ARB_MASK);
			if (ofs_hit(req.addr, `ORM_OFS_HOST_CONTROL) && req.be[0])
			begin
				next_st.regs.host_control = req.wdata[1:0];
			end
			if (ofs_hit(req.addr, `ORM_OFS_HIRQ))
			begin
				if (req.be[2])
				begin
					next_st.regs.host_irq_enable[7:0] = req.wdata[23:16];
				end
				if (req.be[3])
				begin
					next_st.regs.host_irq_enable[15:8] = req.wdata[31:24];
				end
			end
			if (ofs_hit(req.addr, `ORM_OFS_LIRQ))
			begin
				if (req.be[2])
				begin
					next_st.regs.local_irq_enable[7:0] = req.wdata[23:16];
				end
				if (req.be[3])
				begin
					next_st.regs.local_irq_enable[15:8] = req.wdata[31:24];
				end
			end
			if (ofs_hit(req.addr, `ORM_OFS_H2L_MBOX))
				next_st.regs.host_to_local_mailbox = `ORM_MBOX_W'(be_merge(
					{16'h0000, st.regs.host_to_local_mailbox}, req.wdata,
					req.be, `ORM_ALL_MASK));
			if (ofs_hit(req.addr, `ORM_OFS_L2H_MBOX))
				next_st.regs.local_to_host_mailbox = `ORM_MBOX_W'(be_merge(
					{16'h0000, st.regs.local_to_host_mailbox}, req.wdata,
					req.be, `ORM_ALL_MASK));
			if (ofs_hit(req.addr, `ORM_OFS_LBCFG))
				next_st.regs.local_bus_config = be_merge(
					st.regs.local_bus_config, req.wdata, req.be,
					`ORM_ALL_MASK);
			// Writing the soft reset bit returns every register, itself
			// included, to its default; the queues keep their words.
			if (ofs_hit(req.addr, `ORM_OFS_HOST_CONTROL) && req.be[0] &&
				req.wdata[`ORM_HOST_CONTROL_SBIT])
			begin
				next_st.regs = reg_defaults();
			end
		end

		if (sys_rst)
		begin
			next_st                   = '0;
			next_st.regs              = reg_defaults();
			next_st.resp_rdata        = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		st <= next_st;
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign resp.valid = st.resp_valid;
	assign resp.rdata = st.resp_rdata;

	assign ctrl.direct_access_window  = st.regs.direct_access_window;
	assign ctrl.serial_mem_command    = st.regs.serial_mem_command;
	assign ctrl.serial_mem_strobe     = st.serial_mem_strobe;
	assign ctrl.xfer_local_base       = st.regs.xfer_local_base;
	assign ctrl.xfer_host_base        = st.regs.xfer_host_base;
	assign ctrl.xfer_length           = st.regs.xfer_length;
	assign ctrl.xfer_control          = st.regs.xfer_control;
	assign ctrl.arbitration_flags     = st.regs.arbitration_flags;
	assign ctrl.host_control          = st.regs.host_control;
	assign ctrl.host_to_local_mailbox = st.regs.host_to_local_mailbox;
	assign ctrl.local_to_host_mailbox = st.regs.local_to_host_mailbox;
	assign ctrl.local_bus_config      = st.regs.local_bus_config;

	assign host_queue_irq  = not_empty[`ORM_Q_OUT_POST] &
		~st.regs.host_queue_mask;
	assign local_queue_irq = not_empty[`ORM_Q_IN_POST] &
		~st.regs.local_queue_mask;
	assign host_irq  = |(st.regs.host_irq_status & st.regs.host_irq_enable);
	assign local_irq = |(st.regs.local_irq_status &
		st.regs.local_irq_enable);

endmodule : orm_operations_regs

// ===== sim/orm_operations_regs_props.sv
module orm_operations_regs_props
(
	input wire logic               mclk,
	input wire logic               sys_rst,
	input wire orm_pkg::orm_req_t  req,
	input wire orm_pkg::orm_resp_t resp,
	input wire logic               host_queue_irq,
	input wire logic               local_queue_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import orm_pkg::*;
	// ------------------------------------------------------------
	// Register port checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence rd_any;
		req.valid && !req.write;
	endsequence
	sequence rd_at(logic [11:0] a);
		req.valid && !req.write && req.addr[11:2] == a[11:2];
	endsequence

	rd_answer_a: assert property (rd_any |-> ##2 resp.valid)
		else $error("read gave no answer");
	lone_resp_a: assert property (resp.valid |->
		$past(req.valid, 2) && !$past(req.write, 2))
		else $error("answer without a read");
	unmapped_zero_a: assert property (rd_at(12'h050) |->
		##2 resp.rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	stat_unused_a: assert property (rd_at(12'h030) |->
		##2 (resp.rdata & 32'hFFFF_FFF7) == 32'h0000_0000)
		else $error("status unused bits set");
	mask_unused_a: assert property (rd_at(12'h034) |->
		##2 (resp.rdata | 32'h0000_0008) == 32'hFFFF_FFFF)
		else $error("mask unused bits clear");
	host_stat_a: assert property (rd_at(12'h030) ##0 host_queue_irq |->
		##2 resp.rdata[3])
		else $error("status bit misses queue");
	host_mask_a: assert property (rd_at(12'h034) ##0 host_queue_irq |->
		##2 !resp.rdata[3])
		else $error("irq while masked");
	local_mask_a: assert property (rd_at(12'h03C) ##0 local_queue_irq |->
		##2 !resp.rdata[3])
		else $error("local irq while masked");
	reset_quiet_a: assert property ($fell(sys_rst) |->
		(!host_queue_irq && !local_queue_irq) [*2])
		else $error("irq after reset");
endmodule : orm_operations_regs_props

bind orm_operations_regs orm_operations_regs_props
	orm_operations_regs_props_inst
(
	.mclk           (mclk),
	.sys_rst        (sys_rst),
	.req            (req),
	.resp           (resp),
	.host_queue_irq (host_queue_irq),
	.local_queue_irq(local_queue_irq)
);

// ===== sim/orm_host_model.sv
module orm_host_model
(
	input wire logic          mclk,
	output orm_pkg::orm_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	import orm_pkg::*;
	// ------------------------------------------------------------
	// Bus host
	// ------------------------------------------------------------
	initial req = '0;

	// Valid stays up between calls so accesses can run back to back.
	task automatic op(input logic w, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk);
		req <= {1'b1, w, a, be, d};
	endtask : op

	task automatic idle();
		@(posedge mclk);
		req.valid <= 1'b0;
	endtask : idle
endmodule : orm_host_model

// ===== sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import orm_pkg::*;
	// ------------------------------------------------------------
	// Bench and reference model
	// ------------------------------------------------------------
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	orm_req_t    req;
	orm_resp_t   resp;
	logic        hq_irq;
	logic        lq_irq;
	logic        h_irq;
	logic        l_irq;
	orm_ctrl_t   ctrl;
	int          failures = 0;
	int          n_compared = 0;
	logic [31:0] q[4][$];
	logic [31:0] exp_q[$];
	logic        hm;
	logic        lm;
	logic [31:0] rnd = 32'h0001_4C93;
	logic [11:0] dflt[12] = '{12'h030, 12'h034, 12'h038, 12'h03C, 12'h040,
		12'h044, 12'h048, 12'h04C, 12'h4E0, 12'h4FC, 12'h050, 12'h4A0};

	always #4 mclk = ~mclk;

	orm_operations_regs orm_operations_regs_inst
	(
		.mclk(mclk), .sys_rst(sys_rst), .req(req), .resp(resp), .ctrl(ctrl),
		.stat('0), .host_queue_irq(hq_irq), .local_queue_irq(lq_irq),
		.host_irq(h_irq), .local_irq(l_irq)
	);
	orm_host_model orm_host_model_inst (.mclk(mclk), .req(req));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int qid(input logic w, input logic [11:0] a);
		case (a)
			12'h040: return w ? 1 : 0;
			12'h044: return w ? 3 : 2;
			12'h048: return w ? 0 : 1;
			12'h04C: return w ? 2 : 3;
			default: return -1;
		endcase
	endfunction : qid

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want)
		begin
			failures++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask : chk

	task automatic op(input logic w, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] d);
		int          i;
		logic [31:0] e;
		i = qid(w, a);
		if (w)
		begin
			if (i >= 0 && be == 4'hF && q[i].size() < 32)
				q[i].push_back(d);
			if (a == 12'h034 && be[0])
				hm = d[3];
			if (a == 12'h03C && be[0])
				lm = d[3];
		end
		else
		begin
			case (a)
				12'h030: e = {28'h0, q[2].size() != 0, 3'h0};
				12'h034: e = {28'hFFFFFFF, hm, 3'h7};
				12'h038: e = {28'h0, q[1].size() != 0, 3'h0};
				12'h03C: e = {28'hFFFFFFF, lm, 3'h7};
				12'h4E0: e = 32'h0000_0001;
				12'h4FC: e = 32'h0001_0B50;
				default: e = 32'h0000_0000;
			endcase
			if (i >= 0)
				e = q[i].size() != 0 ? q[i].pop_front() : 32'hFFFF_FFFF;
			exp_q.push_back(e);
		end
		orm_host_model_inst.op(w, a, be, d);
	endtask : op

	task automatic settle();
		orm_host_model_inst.idle();
		repeat (3) @(posedge mclk);
		chk({31'h0, hq_irq}, {31'h0, q[2].size() != 0 && !hm});
		chk({31'h0, lq_irq}, {31'h0, q[1].size() != 0 && !lm});
		chk(32'(exp_q.size()), 32'h0);
		chk({30'h0, ctrl.host_control}, 32'h0000_0001);
		chk(ctrl.local_bus_config, 32'h0001_0B50);
		chk({30'h0, h_irq, l_irq}, 32'h0);
	endtask : settle

	task automatic rst();
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (q[k])
			q[k].delete();
		hm = 1'b1;
		lm = 1'b1;
	endtask : rst

	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	always @(posedge mclk)
		if (resp.valid === 1'b1)
		begin
			chk({31'h0, exp_q.size() != 0}, 32'h1);
			if (exp_q.size() != 0)
				chk(resp.rdata, exp_q.pop_front());
		end

	// The run needs some 4000 cycles; the limit allows six times that.
	initial
	begin
		#200_000;
		failures++;
		results();
	end

	initial
	begin
		rst();
		foreach (dflt[k])
			op(1'b0, dflt[k], 4'hF, 32'h0);
		settle();
		for (int k = 0; k < 33; k++)
			op(1'b1, 12'h048, 4'hF, 32'(k) + 32'h100);
		for (int k = 0; k < 34; k++)
			op(1'b0, 12'h040, 4'hF, 32'h0);
		settle();
		op(1'b1, 12'h034, 4'h1, 32'h0);
		op(1'b1, 12'h04C, 4'hF, 32'hA5A5_0001);
		op(1'b1, 12'h044, 4'hE, 32'h1234_5678);
		settle();
		op(1'b0, 12'h030, 4'hF, 32'h0);
		op(1'b0, 12'h04C, 4'hF, 32'h0);
		for (int k = 0; k < 3000; k++)
		begin
			rnd = lfsr(rnd);
			if (rnd[9:8] == 2'h0)
				orm_host_model_inst.idle();
			op(rnd[31], 12'h030 + 12'(4 * (rnd[7:4] % 9)),
				rnd[3] ? 4'hF : rnd[14:11], {rnd[15:0], rnd[31:16]});
		end
		settle();
		op(1'b1, 12'h040, 4'hF, 32'h0000_0055);
		op(1'b1, 12'h04C, 4'hF, 32'h0000_00AA);
		settle();
		rst();
		foreach (dflt[k])
			op(1'b0, dflt[k], 4'hF, 32'h0);
		settle();
		results();
	end
endmodule : tb_top
